/* pfc_consts.svh */
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH

// Register byte offsets
`define PFC_OFF_CTRL 8'h44
`define PFC_OFF_IRQ_STAT 8'h50
`define PFC_OFF_IRQ_MASK 8'h54

// Control/status register field positions
`define PFC_BIT_SW_EN 31
`define PFC_BIT_MCAST 30
`define PFC_BIT_DEST 29
`define PFC_BIT_ACTIVE 23
`define PFC_BIT_SEEN 22
`define PFC_BIT_NEG 21
`define PFC_BIT_LOAD 16
`define PFC_CNT_MSB 15

// Reset values
`define PFC_CTRL_RESET 32'h0000_0000
`define PFC_IRQ_RESET 2'h0

// Interrupt status bit positions
`define PFC_IRQ_FRAME 0
`define PFC_IRQ_DONE 1

// Pause frame layout
`define PFC_RESERVED_DA 48'h0180_C200_0001
`define PFC_ETHERTYPE 16'h8808
`define PFC_OPCODE 16'h0001
`define PFC_IDX_TYPE 5'h0C
`define PFC_IDX_OPCODE 5'h0E
`define PFC_IDX_LEN 5'h10

// Slot timing: 512 bit times, bit time per speed, MCLK period
`define PFC_SLOT_BITS 512
`define PFC_BIT_NS_FAST 10
`define PFC_BIT_NS_SLOW 100
`define PFC_CLK_NS 10
`define PFC_SLOT_CYC_FAST ((`PFC_SLOT_BITS * `PFC_BIT_NS_FAST) / `PFC_CLK_NS)
`define PFC_SLOT_CYC_SLOW ((`PFC_SLOT_BITS * `PFC_BIT_NS_SLOW) / `PFC_CLK_NS)

`endif

/* pfc_pkg.sv */
package pfc_pkg;
  typedef logic [15:0] pfc_count_t;
  typedef logic [12:0] pfc_slot_t;
  typedef logic [4:0] pfc_idx_t;
  typedef enum logic [1:0] {
    PFC_RESP_OKAY = 2'b00,
    PFC_RESP_SLVERR = 2'b10,
    PFC_RESP_DECERR = 2'b11
  } pfc_resp_t;
endpackage

/* pfc_rx_parse.sv */
`timescale 1ns/100ps
`include "pfc_consts.svh"

module pfc_rx_parse (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic srst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic rx_good,
  input wire logic filt_hit,
  output logic done,
  output logic is_pause,
  output logic da_reserved,
  output logic dest_hit,
  output pfc_pkg::pfc_count_t pause_len
);
  import pfc_pkg::*;

  pfc_idx_t cnt;
  pfc_idx_t idx;
  logic da_ok;
  logic type_ok;
  logic op_ok;

  // Expected byte of the reserved group address, first byte on the wire first
  function automatic logic [7:0] da_byte(input pfc_idx_t i);
    logic [47:0] a;
    a = `PFC_RESERVED_DA;
    da_byte = a[8'(47 - 8 * i) -: 8];
  endfunction

  // High or low byte of a 16-bit field
  function automatic logic [7:0] half(input logic [15:0] v, input logic hi);
    half = hi ? v[15:8] : v[7:0];
  endfunction

  assign idx = rx_sof ? 5'h00 : cnt;

  // Byte position within the frame, saturating past the header
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 5'h00;
    end else if (ce) begin
      if (srst) begin
        cnt <= 5'h00;
      end else if (rx_valid && idx != 5'h1F) begin
        cnt <= idx + 5'h01;
      end
    end
  end

  // Header field comparison, byte by byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      da_ok <= 1'b0;
      type_ok <= 1'b0;
      op_ok <= 1'b0;
      pause_len <= 16'h0000;
    end else if (ce) begin
      if (srst) begin
        da_ok <= 1'b0;
        type_ok <= 1'b0;
        op_ok <= 1'b0;
        pause_len <= 16'h0000;
      end else if (rx_valid) begin
        if (idx < 5'h06) begin
          da_ok <= (rx_sof || da_ok) && rx_data == da_byte(idx);
        end
        if (idx == `PFC_IDX_TYPE || idx == `PFC_IDX_TYPE + 5'h01) begin
          type_ok <= (idx == `PFC_IDX_TYPE || type_ok) &&
                     rx_data == half(`PFC_ETHERTYPE, idx == `PFC_IDX_TYPE);
        end
        if (idx == `PFC_IDX_OPCODE || idx == `PFC_IDX_OPCODE + 5'h01) begin
          op_ok <= (idx == `PFC_IDX_OPCODE || op_ok) &&
                   rx_data == half(`PFC_OPCODE, idx == `PFC_IDX_OPCODE);
        end
        if (idx == `PFC_IDX_LEN) begin
          pause_len[15:8] <= rx_data;
        end
        if (idx == `PFC_IDX_LEN + 5'h01) begin
          pause_len[7:0] <= rx_data;
        end
      end
    end
  end

  // Frame verdict, one pulse after the last byte of a good frame of at least 18 bytes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done <= 1'b0;
      is_pause <= 1'b0;
      da_reserved <= 1'b0;
      dest_hit <= 1'b0;
    end else if (ce) begin
      if (srst) begin
        done <= 1'b0;
        is_pause <= 1'b0;
        da_reserved <= 1'b0;
        dest_hit <= 1'b0;
      end else begin
        done <= rx_valid && rx_eof && rx_good && cnt > `PFC_IDX_LEN;
        is_pause <= type_ok && op_ok;
        da_reserved <= da_ok;
        if (rx_valid && rx_eof) begin
          dest_hit <= filt_hit;
        end
      end
    end
  end
endmodule

/* pfc_top.sv */
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "pfc_consts.svh"

module pfc_top #(
  parameter int SLOT_CYC_FAST = `PFC_SLOT_CYC_FAST,
  parameter int SLOT_CYC_SLOW = `PFC_SLOT_CYC_SLOW
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic SRST,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output pfc_pkg::pfc_resp_t BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output pfc_pkg::pfc_resp_t RRESP,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_SOF,
  input wire logic RX_EOF,
  input wire logic RX_GOOD,
  input wire logic RX_PERFECT_HIT,
  input wire logic RX_PATTERN_HIT,
  input wire logic AN_PAUSE_RESOLVED,
  input wire logic CFG_ADV_PAUSE,
  input wire logic SPEED_FAST,
  output logic TX_HOLD,
  output logic IRQ
);
  import pfc_pkg::*;

  logic sw_en;
  logic opt_mcast;
  logic opt_dest;
  logic active;
  logic seen;
  pfc_count_t count;
  pfc_slot_t slot;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic an_meta;
  logic an_sync;
  logic spd_meta;
  logic spd_sync;
  logic neg;
  logic aw_got;
  logic w_got;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic wr_go;
  logic [31:0] ctrl_new;
  logic ctrl_wr;
  logic manual;
  logic sw_off;
  logic fr_done;
  logic fr_pause;
  logic fr_resv;
  logic fr_dest;
  pfc_count_t fr_len;
  logic accept;
  logic slot_end;
  logic finish;
  logic [1:0] ev;
  logic [31:0] ctrl_rd;

  // Merge written bytes over the current value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8 * b +: 8] = d[8 * b +: 8];
      end
    end
    merge = r;
  endfunction

  // Decoded address check used by both channels
  function automatic logic mapped(input logic [7:0] a);
    mapped = a == `PFC_OFF_CTRL || a == `PFC_OFF_IRQ_STAT || a == `PFC_OFF_IRQ_MASK;
  endfunction

  // Two-stage synchronisers for PHY-side levels
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      an_meta <= 1'b0;
      an_sync <= 1'b0;
      spd_meta <= 1'b0;
      spd_sync <= 1'b0;
    end else if (CE) begin
      an_meta <= AN_PAUSE_RESOLVED;
      an_sync <= an_meta;
      spd_meta <= SPEED_FAST;
      spd_sync <= spd_meta;
    end
  end

  pfc_rx_parse u_parse (
    .clk(MCLK),
    .nrst(NRST),
    .ce(CE),
    .srst(SRST),
    .rx_valid(RX_VALID),
    .rx_data(RX_DATA),
    .rx_sof(RX_SOF),
    .rx_eof(RX_EOF),
    .rx_good(RX_GOOD),
    .filt_hit(RX_PERFECT_HIT | RX_PATTERN_HIT),
    .done(fr_done),
    .is_pause(fr_pause),
    .da_reserved(fr_resv),
    .dest_hit(fr_dest),
    .pause_len(fr_len)
  );

  // Frame acceptance and control decode
  assign neg = an_sync & CFG_ADV_PAUSE;
  assign wr_go = aw_got & w_got & ~BVALID;
  assign ctrl_wr = wr_go && wa == `PFC_OFF_CTRL;
  assign ctrl_new = merge({sw_en, opt_mcast, opt_dest, 13'h0000, count}, wd, ws);
  assign manual = ctrl_wr && ws[2] && ctrl_new[`PFC_BIT_LOAD]
                  && !seen && !active;
  assign sw_off = ctrl_wr && ws[3] && sw_en && !ctrl_new[`PFC_BIT_SW_EN];
  assign accept = fr_done && fr_pause && (sw_en || neg)
                  && ((opt_mcast && fr_resv)
                  || (opt_dest && fr_dest));
  assign slot_end = active && slot == 13'h0000;
  assign finish = slot_end && count == 16'h0001;

  // Software-owned control bits
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sw_en <= 1'b0;
      opt_mcast <= 1'b0;
      opt_dest <= 1'b0;
    end else if (CE) begin
      if (SRST) begin
        sw_en <= 1'b0;
        opt_mcast <= 1'b0;
        opt_dest <= 1'b0;
      end else if (ctrl_wr && ws[3]) begin
        sw_en <= ctrl_new[`PFC_BIT_SW_EN];
        opt_mcast <= ctrl_new[`PFC_BIT_MCAST];
        opt_dest <= ctrl_new[`PFC_BIT_DEST];
      end
    end
  end

  // Pause counter and interval flags
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      count <= 16'h0000;
      active <= 1'b0;
      seen <= 1'b0;
    end else if (CE) begin
      if (SRST || sw_off) begin
        count <= 16'h0000;
        active <= 1'b0;
        seen <= 1'b0;
      end else if (accept) begin
        count <= fr_len;
        active <= fr_len != 16'h0000;
        seen <= fr_len != 16'h0000;
      end else if (manual) begin
        count <= ctrl_new[`PFC_CNT_MSB:0];
        active <= ctrl_new[`PFC_CNT_MSB:0] != 16'h0000;
      end else if (slot_end) begin
        count <= count - 16'h0001;
        if (finish) begin
          active <= 1'b0;
          seen <= 1'b0;
        end
      end
    end
  end

  // Slot-time prescaler, reloaded whenever a new interval starts
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      slot <= 13'h0000;
    end else if (CE) begin
      if (SRST || accept || manual || slot_end || !active) begin
        slot <= spd_sync ? 13'(SLOT_CYC_FAST - 1) : 13'(SLOT_CYC_SLOW - 1);
      end else begin
        slot <= slot - 13'h0001;
      end
    end
  end

  // Transmit hold follows the active interval
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      TX_HOLD <= 1'b0;
    end else if (CE) begin
      TX_HOLD <= !SRST && !sw_off && (accept ? fr_len != 16'h0000
                 : manual ? ctrl_new[`PFC_CNT_MSB:0] != 16'h0000
                 : active && !finish);
    end
  end

  // Sticky event bits; a new event wins over a write-one clear
  assign ev = {finish, accept};
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      irq_stat <= `PFC_IRQ_RESET;
      irq_mask <= `PFC_IRQ_RESET;
      IRQ <= 1'b0;
    end else if (CE) begin
      if (SRST) begin
        irq_stat <= `PFC_IRQ_RESET;
        irq_mask <= `PFC_IRQ_RESET;
        IRQ <= 1'b0;
      end else begin
        if (wr_go && wa == `PFC_OFF_IRQ_STAT && ws[0]) begin
          irq_stat <= (irq_stat & ~wd[1:0]) | ev;
        end else begin
          irq_stat <= irq_stat | ev;
        end
        if (wr_go && wa == `PFC_OFF_IRQ_MASK && ws[0]) begin
          irq_mask <= wd[1:0];
        end
        IRQ <= |(irq_stat & irq_mask);
      end
    end
  end

  // Write address and data channels, taken in either order
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wa <= 8'h00;
      wd <= 32'h0000_0000;
      ws <= 4'h0;
    end else if (CE) begin
      if (AWVALID && AWREADY) begin
        AWREADY <= 1'b0;
        aw_got <= 1'b1;
        wa <= {AWADDR[7:2], 2'b00};
      end else begin
        AWREADY <= !aw_got && !BVALID;
      end
      if (WVALID && WREADY) begin
        WREADY <= 1'b0;
        w_got <= 1'b1;
        wd <= WDATA;
        ws <= WSTRB;
      end else begin
        WREADY <= !w_got && !BVALID;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      BVALID <= 1'b0;
      BRESP <= PFC_RESP_OKAY;
    end else if (CE) begin
      if (wr_go) begin
        BVALID <= 1'b1;
        BRESP <= mapped(wa) ? PFC_RESP_OKAY : PFC_RESP_DECERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Read view: load bit always zero, count is live
  assign ctrl_rd = {sw_en, opt_mcast, opt_dest, 5'h00, active, seen, neg,
                    4'h0, 1'b0, count};

  // Read channel with registered data
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= PFC_RESP_OKAY;
    end else if (CE) begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RRESP <= mapped({ARADDR[7:2], 2'b00}) ? PFC_RESP_OKAY : PFC_RESP_DECERR;
        case ({ARADDR[7:2], 2'b00})
          `PFC_OFF_CTRL: RDATA <= ctrl_rd;
          `PFC_OFF_IRQ_STAT: RDATA <= {30'h0000_0000, irq_stat};
          `PFC_OFF_IRQ_MASK: RDATA <= {30'h0000_0000, irq_mask};
          default: RDATA <= 32'h0000_0000;
        endcase
      end else begin
        if (RVALID && RREADY) begin
          RVALID <= 1'b0;
        end
        ARREADY <= !RVALID || RREADY ? !(RVALID && !RREADY) && !RVALID : 1'b0;
      end
    end
  end
endmodule

/* pfc_top_assertions.sv */
`timescale 1ns/100ps
module pfc_chk (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [7:0] ARADDR,
  input wire logic AWREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic RX_VALID,
  input wire logic RX_EOF,
  input wire logic CFG_ADV_PAUSE,
  input wire logic TX_HOLD
);
  logic rd_ctrl;
  logic [2:0] since;
  // Notes whether the read under way targets the control register
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) rd_ctrl <= 1'b0;
    else if (ARVALID && ARREADY) rd_ctrl <= (ARADDR[7:2] == 6'h11);
  end
  // Cycles since a frame end or a write answer, saturating
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) since <= 3'h7;
    else if ((RX_VALID && RX_EOF) || BVALID) since <= 3'h0;
    else if (since != 3'h7) since <= since + 3'h1;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  property p_load_rd0; RVALID && rd_ctrl |-> !RDATA[16]; endproperty
  a_load_rd0: assert property (p_load_rd0) else $error("load bit read high");
  property p_unused; RVALID && rd_ctrl |-> RDATA[28:24] == 5'h00 && RDATA[20:17] == 4'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits not zero");
  property p_act; $rose(RVALID) && rd_ctrl |-> RDATA[23] == $past(TX_HOLD); endproperty
  a_act: assert property (p_act) else $error("active flag differs from hold");
  property p_neg; $rose(RVALID) && rd_ctrl && RDATA[21] |-> $past(CFG_ADV_PAUSE); endproperty
  a_neg: assert property (p_neg) else $error("negotiated flag without advert");
  property p_cause; $rose(TX_HOLD) |-> BVALID || since <= 3'h4; endproperty
  a_cause: assert property (p_cause) else $error("hold rose without cause");
  property p_b_once; BVALID && BREADY |=> !BVALID; endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_r_once; RVALID && RREADY |=> !RVALID; endproperty
  a_r_once: assert property (p_r_once) else $error("read answer repeated");
  property p_aw_ref; BVALID |-> !AWREADY; endproperty
  a_aw_ref: assert property (p_aw_ref) else $error("write taken during answer");
  property p_ar_ref; RVALID |-> !ARREADY; endproperty
  a_ar_ref: assert property (p_ar_ref) else $error("read taken during answer");
  c_hold: cover property ($rose(TX_HOLD));
  c_seen: cover property (RVALID && rd_ctrl && RDATA[22]);
  c_write: cover property (BVALID && BREADY);
endmodule
bind pfc_top pfc_chk u_pfc_chk (.MCLK(MCLK), .NRST(NRST), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .ARADDR(ARADDR), .AWREADY(AWREADY), .RVALID(RVALID), .RREADY(RREADY),
  .RDATA(RDATA), .BVALID(BVALID), .BREADY(BREADY), .RX_VALID(RX_VALID), .RX_EOF(RX_EOF),
  .CFG_ADV_PAUSE(CFG_ADV_PAUSE), .TX_HOLD(TX_HOLD));

/* pfc_peer.sv */
`timescale 1ns/100ps
`include "pfc_consts.svh"
module pfc_peer (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_sof,
  output logic rx_eof,
  output logic rx_good,
  output logic perf_hit,
  output logic pat_hit
);
  initial begin
    {rx_valid, rx_sof, rx_eof, rx_good, perf_hit, pat_hit} = 6'h00;
    rx_data = 8'h00;
  end
  // Sends one pause frame; lines not qualified carry changing junk
  task automatic send(input logic [47:0] da, input logic [15:0] len, input logic good,
                      input logic p, input logic t, input int gap);
    logic [159:0] f;
    f = {da, 48'h0200_0000_0042, `PFC_ETHERTYPE, `PFC_OPCODE, len, 16'hA5A5};
    for (int i = 0; i < 20; i++) begin
      repeat (gap) begin
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= f[159 - 8 * i -: 8];
      rx_sof <= (i == 0);
      rx_eof <= (i == 19);
      rx_good <= (i == 19) ? good : ~rx_good;
      perf_hit <= (i == 19) ? p : ~perf_hit;
      pat_hit <= (i == 19) ? t : ~pat_hit;
    end
    @(posedge clk);
    {rx_valid, rx_sof, rx_eof} <= 3'h0;
    rx_data <= ~rx_data;
  endtask
endmodule

/* pfc_top_bench.sv */
`timescale 1ns/100ps
`include "pfc_consts.svh"
module pfc_top_bench;
  import pfc_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, srst = 1'b0, an = 1'b0, cfg = 1'b0, fast = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdv;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, tx_hold, irq;
  logic rxv, rxs, rxe, rxg, rxp, rxt, sw, mc, dao, rsv, p, t, g, a, neg;
  logic [7:0] rxd;
  logic [31:0] rdata;
  pfc_resp_t bresp, rresp, resp;
  int fails = 0, n_tests = 0, hold_cyc = 0;
  // Clock and hold-time tally
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (tx_hold === 1'b1) hold_cyc <= hold_cyc + 1;
  pfc_top #(.SLOT_CYC_FAST(4), .SLOT_CYC_SLOW(8)) u_pfc_top (.MCLK(mclk), .NRST(nrst),
    .CE(1'b1), .SRST(srst), .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
    .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid),
    .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
    .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp), .RX_VALID(rxv),
    .RX_DATA(rxd), .RX_SOF(rxs), .RX_EOF(rxe), .RX_GOOD(rxg), .RX_PERFECT_HIT(rxp),
    .RX_PATTERN_HIT(rxt), .AN_PAUSE_RESOLVED(an), .CFG_ADV_PAUSE(cfg), .SPEED_FAST(fast),
    .TX_HOLD(tx_hold), .IRQ(irq));
  pfc_peer u_pfc_peer (.clk(mclk), .rx_valid(rxv), .rx_data(rxd), .rx_sof(rxs),
    .rx_eof(rxe), .rx_good(rxg), .perf_hit(rxp), .pat_hit(rxt));
  // Verdict and run end
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask
  task tmo;
    fails++;
    $display("unexpected wait expected answer seen none");
    wrap_up;
  endtask
  // Bus write: both channels offered, each dropped once taken
  task wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= ad;
    wdata <= d;
    wstrb <= 4'hF;
    for (int i = 0; i <= 100; i++) begin
      if (i == 100) tmo;
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task rd(input logic [7:0] ad);
    @(posedge mclk);
    {arvalid, rready} <= 2'h3;
    araddr <= ad;
    for (int i = 0; i <= 100; i++) begin
      if (i == 100) tmo;
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rdv = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task wait_idle;
    for (int i = 0; tx_hold !== 1'b0; i++) begin
      if (i > 400) tmo;
      @(posedge mclk);
    end
  endtask
  function logic [31:0] ctrl(input logic s, m, d, ac, se, ng);
    return {s, m, d, 5'h00, ac, se, ng, 5'h00, 16'h0000};
  endfunction
  function logic accept(input logic s, ng, m, d, r, pp, tt, gg);
    return (s | ng) & gg & ((m & r) | (d & (pp | tt)));
  endfunction
  // Main sequence
  initial begin
    void'($urandom(32'hD80C));
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(`PFC_OFF_CTRL);
    chk("ctrl reset", 32'h0, rdv);
    rd(8'h40);
    chk("unmapped resp", PFC_RESP_DECERR, resp);
    fast <= 1'b0;
    repeat (4) @(posedge mclk);
    hold_cyc <= 0;
    wr(`PFC_OFF_CTRL, 32'h0001_0003);
    wr(`PFC_OFF_CTRL, 32'h0001_0009);
    rd(`PFC_OFF_CTRL);
    chk("manual flags", 32'h0080_0000, rdv & 32'hFFFF_0000);
    chk("manual count", 1, rdv[15:0] inside {[1:3]});
    wait_idle;
    chk("manual span", 1, hold_cyc inside {[17:27]});
    rd(`PFC_OFF_CTRL);
    chk("ctrl idle", 32'h0, rdv);
    rd(`PFC_OFF_IRQ_STAT);
    chk("irq stat", 32'h2, rdv);
    chk("irq masked", 0, irq);
    wr(`PFC_OFF_IRQ_MASK, 32'h2);
    repeat (3) @(posedge mclk);
    chk("irq raised", 1, irq);
    wr(`PFC_OFF_IRQ_STAT, 32'h2);
    repeat (3) @(posedge mclk);
    chk("irq cleared", 0, irq);
    // Random pause frames against random enables and filters
    for (int k = 0; k < 14; k++) begin
      {sw, mc, dao, rsv, p, t} = $urandom;
      g = $urandom_range(0, 7) != 0;
      if (k == 1) {sw, mc, rsv, p, t, dao} = 6'h38;
      an <= $urandom;
      cfg <= $urandom;
      fast <= $urandom;
      wr(`PFC_OFF_CTRL, {sw, mc, dao, 29'h0});
      repeat (6) @(posedge mclk);
      neg = an & cfg;
      a = accept(sw, neg, mc, dao, rsv, p, t, g);
      u_pfc_peer.send(rsv ? `PFC_RESERVED_DA : 48'h0200_0000_0007, 16'h0008 + k, g, p, t,
                      k % 3);
      repeat (3) @(posedge mclk);
      rd(`PFC_OFF_CTRL);
      chk("frame flags", ctrl(sw, mc, dao, a, a, neg), rdv & 32'hFFFF_0000);
      chk("tx hold", a, tx_hold);
      if (a && sw) begin
        wr(`PFC_OFF_CTRL, {1'b0, mc, dao, 29'h0});
        rd(`PFC_OFF_CTRL);
        chk("sw stop", ctrl(1'b0, mc, dao, 1'b0, 1'b0, neg), rdv & 32'hFFFF_0000);
      end else begin
        wait_idle;
        rd(`PFC_OFF_CTRL);
        chk("frame done", ctrl(sw, mc, dao, 1'b0, 1'b0, neg), rdv);
      end
      wr(`PFC_OFF_IRQ_STAT, 32'h3);
    end
    // Soft reset clears the software-owned control bits; the negotiated flag is kept
    wr(`PFC_OFF_CTRL, 32'hE000_0000);
    @(posedge mclk);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    rd(`PFC_OFF_CTRL);
    chk("soft reset", ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, neg), rdv);
    wrap_up;
  end
endmodule
